// File: common/ampwm_pkg.sv
// constants, register map and state types of the pwm output control block
// What this block does
// - twelve pwm engines, each one enabled on its own and routed to any pin.
// - every pwm pin has a polarity bit that inverts the driven level.
// - each engine has its own dead time and minimum pulse, with stagger.
// - am avoidance swaps the carrier to a second, programmable period.
// - master clock runs only when enabled, at one of two rates, else low.
// - supply sync toggles at one of six ratios locked to the carrier.
// - fault pin shows any detected protect fault only while enabled.
// - idle mode stops all engines after audio stays under a level a while.
// - idle mode is off after reset until software turns it on.
// - power-down pin holds power stages off at startup and on a fault.
// - protect input n shuts down engine n, for the first eight engines.
package ampwm_pkg;
    localparam int NUM_ENG = 12;
    localparam int NUM_PROT = 8;
    localparam int PER_W = 10;
    // byte offsets on the register bus
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_PERIOD = 12'h004;
    localparam logic [11:0] OFF_ENG_EN = 12'h008;
    localparam logic [11:0] OFF_IDLE_LVL = 12'h00C;
    localparam logic [11:0] OFF_IDLE_TIME = 12'h010;
    localparam logic [11:0] OFF_STATUS = 12'h014;
    localparam logic [11:0] OFF_IRQ_EN = 12'h018;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h01C;
    localparam logic [11:0] OFF_STAGGER = 12'h020;
    localparam logic [5:0] BLK_TIMING = 6'h01;
    localparam logic [5:0] BLK_PINMAP = 6'h02;
    // field positions
    localparam int PERIOD_ALT_LSB = 16;
    localparam int STS_LIVE_LSB = 8;
    localparam int STS_PROT_LSB = 16;
    localparam int EV_FAULT = 0;
    localparam int EV_IDLE_ON = 1;
    localparam int EV_IDLE_OFF = 2;
    // reset values
    localparam logic [9:0] PER_NORM_RST = 10'h1F4;
    localparam logic [9:0] PER_ALT_RST = 10'h1C2;
    localparam logic [15:0] IDLE_LVL_RST = 16'h0010;
    localparam logic [15:0] IDLE_TIME_RST = 16'hFFFF;
    // master clock half periods in system clocks
    localparam logic [3:0] MCLK_HALF_A = 4'h1;
    localparam logic [3:0] MCLK_HALF_B = 4'h2;

    typedef struct packed {
        logic [2:0] sync_ratio;
        logic pdn_en;
        logic idle_en;
        logic fault_en;
        logic sync_en;
        logic mclk_sel;
        logic mclk_en;
        logic am_en;
        logic run;
    } ampwm_ctrl_t;
    typedef struct packed {
        logic [7:0] minpw;
        logic [7:0] dead;
    } ampwm_tim_t;
    typedef struct packed {
        logic inv;
        logic low_side;
        logic [3:0] eng;
    } ampwm_pin_t;
    typedef struct packed {
        logic raw;
        logic [7:0] dcnt;
        logic hi;
        logic lo;
    } ampwm_eng_st_t;
    typedef struct packed {
        logic [3:0] cnt;
        logic out;
    } ampwm_div_st_t;
    typedef struct packed {
        ampwm_ctrl_t ctrl;
        logic [9:0] per_norm;
        logic [9:0] per_alt;
        logic [9:0] per;
        logic [9:0] cnt;
        logic [9:0] stg;
        logic [11:0] en;
        ampwm_tim_t [11:0] tim;
        ampwm_pin_t [11:0] pin;
        logic [15:0] lvl;
        logic [15:0] itime;
        logic [15:0] icnt;
        logic idle;
        logic [7:0] prot_m;
        logic [7:0] prot_s;
        logic fault;
        logic [2:0] sts;
        logic [2:0] irq_en;
        logic [11:0] pwm;
        logic fault_o;
        logic pdn_o;
        logic irq;
        logic [31:0] rdata;
        logic slverr;
    } ampwm_st_t;
endpackage

// File: logic/ampwm_div.sv
// toggle divider used for the master clock and the supply sync output
`timescale 1ns/1ps
module ampwm_div (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // control
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic [3:0] i_half,
    // output
    output logic o_clk
);
    ampwm_pkg::ampwm_div_st_t s_q;
    ampwm_pkg::ampwm_div_st_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (!i_run)
        begin
            s_d.cnt = 4'h0;
            s_d.out = 1'b0;
        end
        else if (i_tick)
        begin
            // a zero half count behaves as one so the output never stalls
            if (s_q.cnt + 4'h1 >= i_half)
            begin
                s_d.cnt = 4'h0;
                s_d.out = ~s_q.out;
            end
            else
                s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign o_clk = s_q.out;
endmodule

// File: logic/ampwm_engine.sv
// one pwm engine: compare, minimum pulse clamp and dead time
`timescale 1ns/1ps
module ampwm_engine (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // carrier and settings
    input wire logic i_on,
    input wire logic [9:0] i_phase,
    input wire logic [9:0] i_period,
    input wire logic [9:0] i_duty,
    input wire ampwm_pkg::ampwm_tim_t i_tim,
    // complementary outputs, both low when off
    output logic o_hi,
    output logic o_lo
);
    ampwm_pkg::ampwm_eng_st_t s_q;
    ampwm_pkg::ampwm_eng_st_t s_d;
    logic [9:0] duty_eff;
    logic raw_n;

    always_comb
    begin
        s_d = s_q;
        // pulses narrower than the minimum collapse to fully off or on
        if (i_duty < {2'h0, i_tim.minpw})
            duty_eff = 10'h000;
        else if ({1'b0, i_duty} + {3'h0, i_tim.minpw} > {1'b0, i_period})
            duty_eff = i_period;
        else
            duty_eff = i_duty;
        raw_n = i_on && (i_phase < duty_eff);
        if (raw_n != s_q.raw)
            s_d.dcnt = 8'h00;
        else if (s_q.dcnt != 8'hFF)
            s_d.dcnt = s_q.dcnt + 8'h01;
        s_d.raw = raw_n;
        // each side waits out the dead time after every edge
        s_d.hi = i_on && raw_n && (s_d.dcnt >= i_tim.dead);
        s_d.lo = i_on && !raw_n && (s_d.dcnt >= i_tim.dead);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign o_hi = s_q.hi;
    assign o_lo = s_q.lo;
endmodule

// File: logic/ampwm_top.sv
// pwm output stage control: carrier, engines, pin routing, apb registers
`timescale 1ns/1ps
module ampwm_top #(
    parameter int NUM_PINS = ampwm_pkg::NUM_ENG
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // audio side, same clock
    input wire logic [11:0][9:0] i_duty,
    input wire logic [15:0] i_audio_level,
    // protect pins, asynchronous
    input wire logic [7:0] i_engine_protect_in,
    // pwm pins
    output logic [NUM_PINS-1:0] o_pwm_pin,
    // assignable outputs and their enables
    output logic o_fault_out,
    output logic o_fault_oe,
    output logic o_idle_out,
    output logic o_idle_oe,
    output logic o_power_down,
    output logic o_power_down_oe,
    output logic o_mclk,
    output logic o_mclk_oe,
    output logic o_supply_sync_out,
    output logic o_supply_sync_oe,
    // interrupt
    output logic o_irq
);
    ampwm_pkg::ampwm_st_t s_q;
    ampwm_pkg::ampwm_st_t s_d;
    logic [11:0] eng_on;
    logic [11:0] eng_hi;
    logic [11:0] eng_lo;
    logic [11:0][9:0] phase;
    logic wrap;
    logic [9:0] quarter;
    logic sync_tick;
    logic [3:0] sync_half;
    logic wr_acc;
    logic rd_setup;
    logic [2:0] ev;

    assign wrap = s_q.cnt >= s_q.per - 10'h001;
    assign quarter = {2'h0, s_q.per[9:2]};

    // engines, each shifted in phase by its index times the stagger
    genvar g;
    generate
        for (g = 0; g < ampwm_pkg::NUM_ENG; g++)
        begin : g_eng
            logic [13:0] off;
            logic [14:0] sum;
            logic prot;
            assign off = 14'(g) * {4'h0, s_q.stg};
            always_comb
            begin
                sum = {1'b0, off} + {5'h00, s_q.cnt};
                if (sum >= {5'h00, s_q.per})
                    sum = sum - {5'h00, s_q.per};
            end
            assign phase[g] = sum[9:0];
            if (g < ampwm_pkg::NUM_PROT)
                assign prot = s_q.prot_s[g];
            else
                assign prot = 1'b0;
            assign eng_on[g] = s_q.en[g] && s_q.ctrl.run && !s_q.idle && !prot;
            ampwm_engine u_eng (
                .i_clk(i_clk),
                .i_srst(i_srst),
                .i_on(eng_on[g]),
                .i_phase(phase[g]),
                .i_period(s_q.per),
                .i_duty(i_duty[g]),
                .i_tim(s_q.tim[g]),
                .o_hi(eng_hi[g]),
                .o_lo(eng_lo[g])
            );
        end
    endgenerate

    // six sync ratios: 2x, 1x, 1/2, 1/4, 1/8, 1/16 of the carrier rate
    always_comb
    begin
        sync_tick = wrap;
        sync_half = 4'h1;
        unique case (s_q.ctrl.sync_ratio)
            3'h0: sync_tick = (s_q.cnt == 10'h000) || (s_q.cnt == quarter)
                || (s_q.cnt == {quarter[8:0], 1'b0})
                || (s_q.cnt == quarter + {quarter[8:0], 1'b0});
            3'h1: sync_tick = (s_q.cnt == 10'h000)
                || (s_q.cnt == {quarter[8:0], 1'b0});
            3'h2: sync_half = 4'h1;
            3'h3: sync_half = 4'h2;
            3'h4: sync_half = 4'h4;
            default: sync_half = 4'h8;
        endcase
    end

    ampwm_div u_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_run(s_q.ctrl.sync_en),
        .i_tick(sync_tick),
        .i_half(sync_half),
        .o_clk(o_supply_sync_out)
    );

    ampwm_div u_mclk (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_run(s_q.ctrl.mclk_en),
        .i_tick(1'b1),
        .i_half(s_q.ctrl.mclk_sel ? ampwm_pkg::MCLK_HALF_B
            : ampwm_pkg::MCLK_HALF_A),
        .o_clk(o_mclk)
    );

    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign rd_setup = i_psel && !i_penable;

    always_comb
    begin
        s_d = s_q;
        ev = 3'h0;
        // carrier; a new period is taken only at the wrap, so no runt cycle
        if (wrap)
        begin
            s_d.cnt = 10'h000;
            s_d.per = s_q.ctrl.am_en ? s_q.per_alt : s_q.per_norm;
        end
        else
            s_d.cnt = s_q.cnt + 10'h001;
        // protect pins pass two flops before use
        s_d.prot_m = i_engine_protect_in;
        s_d.prot_s = s_q.prot_m;
        s_d.fault = |s_q.prot_s;
        if (s_d.fault && !s_q.fault)
            ev[ampwm_pkg::EV_FAULT] = 1'b1;
        // idle timer counts carrier periods spent under the level
        if (!s_q.ctrl.idle_en || i_audio_level >= s_q.lvl)
        begin
            s_d.icnt = 16'h0000;
            s_d.idle = 1'b0;
        end
        else
        begin
            if (wrap && s_q.icnt != 16'hFFFF)
                s_d.icnt = s_q.icnt + 16'h0001;
            s_d.idle = s_q.icnt >= s_q.itime;
        end
        if (s_d.idle && !s_q.idle)
            ev[ampwm_pkg::EV_IDLE_ON] = 1'b1;
        if (!s_d.idle && s_q.idle)
            ev[ampwm_pkg::EV_IDLE_OFF] = 1'b1;
        // pin routing and polarity
        for (int p = 0; p < NUM_PINS; p++)
        begin
            if (s_q.pin[p].eng < 4'(ampwm_pkg::NUM_ENG))
                s_d.pwm[p] = (s_q.pin[p].low_side ? eng_lo[s_q.pin[p].eng]
                    : eng_hi[s_q.pin[p].eng]) ^ s_q.pin[p].inv;
            else
                s_d.pwm[p] = s_q.pin[p].inv;
        end
        s_d.fault_o = s_q.ctrl.fault_en && s_q.fault;
        s_d.pdn_o = s_q.ctrl.pdn_en && (!s_q.ctrl.run || s_q.fault);
        // register writes land in the access cycle
        if (wr_acc)
        begin
            unique case (i_paddr)
                ampwm_pkg::OFF_CTRL: s_d.ctrl = i_pwdata[10:0];
                ampwm_pkg::OFF_PERIOD:
                begin
                    s_d.per_norm = i_pwdata[9:0];
                    s_d.per_alt = i_pwdata[ampwm_pkg::PERIOD_ALT_LSB+:10];
                end
                ampwm_pkg::OFF_ENG_EN: s_d.en = i_pwdata[11:0];
                ampwm_pkg::OFF_IDLE_LVL: s_d.lvl = i_pwdata[15:0];
                ampwm_pkg::OFF_IDLE_TIME: s_d.itime = i_pwdata[15:0];
                ampwm_pkg::OFF_IRQ_EN: s_d.irq_en = i_pwdata[2:0];
                ampwm_pkg::OFF_STAGGER: s_d.stg = i_pwdata[9:0];
                default:
                begin
                    if (i_paddr[11:6] == ampwm_pkg::BLK_TIMING
                        && i_paddr[5:2] < 4'(ampwm_pkg::NUM_ENG))
                        s_d.tim[i_paddr[5:2]] = i_pwdata[15:0];
                    if (i_paddr[11:6] == ampwm_pkg::BLK_PINMAP
                        && i_paddr[5:2] < 4'(NUM_PINS))
                        s_d.pin[i_paddr[5:2]] = i_pwdata[5:0];
                end
            endcase
        end
        // sticky status: a new event beats a clear in the same cycle
        if (wr_acc && i_paddr == ampwm_pkg::OFF_IRQ_CLR)
            s_d.sts = (s_q.sts & ~i_pwdata[2:0]) | ev;
        else
            s_d.sts = s_q.sts | ev;
        s_d.irq = |(s_d.sts & s_d.irq_en);
        // read data is fetched in setup so the access needs no wait
        if (rd_setup)
        begin
            s_d.rdata = 32'h0000_0000;
            s_d.slverr = 1'b0;
            unique case (i_paddr)
                ampwm_pkg::OFF_CTRL: s_d.rdata[10:0] = s_q.ctrl;
                ampwm_pkg::OFF_PERIOD:
                begin
                    s_d.rdata[9:0] = s_q.per_norm;
                    s_d.rdata[ampwm_pkg::PERIOD_ALT_LSB+:10] = s_q.per_alt;
                end
                ampwm_pkg::OFF_ENG_EN: s_d.rdata[11:0] = s_q.en;
                ampwm_pkg::OFF_IDLE_LVL: s_d.rdata[15:0] = s_q.lvl;
                ampwm_pkg::OFF_IDLE_TIME: s_d.rdata[15:0] = s_q.itime;
                ampwm_pkg::OFF_STATUS:
                begin
                    s_d.rdata[2:0] = s_q.sts;
                    s_d.rdata[ampwm_pkg::STS_LIVE_LSB] = s_q.fault;
                    s_d.rdata[ampwm_pkg::STS_LIVE_LSB+1] = s_q.idle;
                    s_d.rdata[ampwm_pkg::STS_PROT_LSB+:8] = s_q.prot_s;
                end
                ampwm_pkg::OFF_IRQ_EN: s_d.rdata[2:0] = s_q.irq_en;
                ampwm_pkg::OFF_IRQ_CLR: s_d.rdata = 32'h0000_0000;
                ampwm_pkg::OFF_STAGGER: s_d.rdata[9:0] = s_q.stg;
                default:
                begin
                    if (i_paddr[11:6] == ampwm_pkg::BLK_TIMING
                        && i_paddr[5:2] < 4'(ampwm_pkg::NUM_ENG))
                        s_d.rdata[15:0] = s_q.tim[i_paddr[5:2]];
                    else if (i_paddr[11:6] == ampwm_pkg::BLK_PINMAP
                        && i_paddr[5:2] < 4'(NUM_PINS))
                        s_d.rdata[5:0] = s_q.pin[i_paddr[5:2]];
                    else
                        s_d.slverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            s_q <= '0;
            s_q.per_norm <= ampwm_pkg::PER_NORM_RST;
            s_q.per_alt <= ampwm_pkg::PER_ALT_RST;
            s_q.per <= ampwm_pkg::PER_NORM_RST;
            s_q.lvl <= ampwm_pkg::IDLE_LVL_RST;
            s_q.itime <= ampwm_pkg::IDLE_TIME_RST;
        end
        else
            s_q <= s_d;
    end

    assign o_prdata = s_q.rdata;
    assign o_pready = 1'b1;
    assign o_pslverr = s_q.slverr && i_psel && i_penable && !i_pwrite;
    assign o_pwm_pin = s_q.pwm;
    assign o_fault_out = s_q.fault_o;
    assign o_fault_oe = s_q.ctrl.fault_en;
    assign o_idle_out = s_q.idle;
    assign o_idle_oe = s_q.ctrl.idle_en;
    assign o_power_down = s_q.pdn_o;
    assign o_power_down_oe = s_q.ctrl.pdn_en;
    assign o_mclk_oe = s_q.ctrl.mclk_en;
    assign o_supply_sync_oe = s_q.ctrl.sync_en;
    assign o_irq = s_q.irq;

    // checks
    sequence s_mclk_off2;
        !s_q.ctrl.mclk_en [*2];
    endsequence
    sequence s_sync_off2;
        !s_q.ctrl.sync_en [*2];
    endsequence

    property p_idle_gated;
        @(posedge i_clk) disable iff (i_srst)
        !s_q.ctrl.idle_en |=> !o_idle_out;
    endproperty
    a_idle_gated: assert property (p_idle_gated)
        else $error("idle active while disabled");

    property p_fault_pin;
        @(posedge i_clk) disable iff (i_srst)
        $rose(i_engine_protect_in[0]) && s_q.ctrl.fault_en
        ##1 s_q.ctrl.fault_en [*3] |=> o_fault_out;
    endproperty
    a_fault_pin: assert property (p_fault_pin)
        else $error("fault pin missed a protect event");

    property p_pdn_start;
        @(posedge i_clk) disable iff (i_srst)
        s_q.ctrl.pdn_en && !s_q.ctrl.run |=> o_power_down;
    endproperty
    a_pdn_start: assert property (p_pdn_start)
        else $error("power down not held during startup");

    property p_mclk_off;
        @(posedge i_clk) disable iff (i_srst)
        s_mclk_off2 |-> !o_mclk;
    endproperty
    a_mclk_off: assert property (p_mclk_off)
        else $error("master clock runs while disabled");

    property p_sync_off;
        @(posedge i_clk) disable iff (i_srst)
        s_sync_off2 |-> !o_supply_sync_out;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("supply sync runs while disabled");

    property p_protect_stop;
        @(posedge i_clk) disable iff (i_srst)
        s_q.prot_s[0] |=> !eng_hi[0] && !eng_lo[0];
    endproperty
    a_protect_stop: assert property (p_protect_stop)
        else $error("engine 0 drives while protected");

    property p_no_overlap;
        @(posedge i_clk) disable iff (i_srst)
        !(eng_hi[0] && eng_lo[0]);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both sides of engine 0 on");

    property p_am_period;
        @(posedge i_clk) disable iff (i_srst)
        wrap && s_q.ctrl.am_en |=> s_q.per == $past(s_q.per_alt);
    endproperty
    a_am_period: assert property (p_am_period)
        else $error("carrier not on alternate period");

    property p_off_level;
        @(posedge i_clk) disable iff (i_srst)
        (s_q.pin[0].eng == 4'h0 && !s_q.en[0]) [*3]
        |-> o_pwm_pin[0] == $past(s_q.pin[0].inv);
    endproperty
    a_off_level: assert property (p_off_level)
        else $error("pin 0 not idle for a disabled engine");

    property p_idle_stop;
        @(posedge i_clk) disable iff (i_srst)
        s_q.idle [*2] |-> eng_hi == 12'h000 && eng_lo == 12'h000;
    endproperty
    a_idle_stop: assert property (p_idle_stop)
        else $error("engines run in idle shutdown");
endmodule

// File: test/ampwm_stage_model.sv
// power stage model: reports a commanded fault on its protect line
`timescale 1ns/1ps
module ampwm_stage_model (
    // clock
    input wire logic i_clk,
    // faults the bench commands
    input wire logic [7:0] i_fault_req,
    // protect lines into the block
    output logic [7:0] o_protect
);
    logic [7:0] cmp_q;
    // a real comparator reports a little late, so two clocks of delay
    always_ff @(posedge i_clk)
    begin
        cmp_q <= i_fault_req;
        o_protect <= cmp_q;
    end
endmodule

// File: test/tb_amp_pwm_output_control.sv
// self-checking bench of the pwm output control block
`timescale 1ns/1ps
module tb_amp_pwm_output_control;
    logic i_clk, i_srst, i_psel, i_penable, i_pwrite, err;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic o_pready, o_pslverr, o_fault_out, o_fault_oe, o_idle_out;
    logic o_idle_oe, o_power_down, o_power_down_oe, o_mclk, o_mclk_oe;
    logic o_supply_sync_out, o_supply_sync_oe, o_irq;
    logic [11:0][9:0] i_duty;
    logic [15:0] i_audio_level;
    logic [7:0] prot, flt_req;
    logic [11:0] o_pwm_pin;
    int fail_count = 0;
    int n_compared = 0;
    int p, h;
    int mul[6] = '{1, 2, 4, 8, 16, 32};

    ampwm_top u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_duty(i_duty),
        .i_audio_level(i_audio_level), .i_engine_protect_in(prot),
        .o_pwm_pin(o_pwm_pin), .o_fault_out(o_fault_out),
        .o_fault_oe(o_fault_oe), .o_idle_out(o_idle_out),
        .o_idle_oe(o_idle_oe), .o_power_down(o_power_down),
        .o_power_down_oe(o_power_down_oe), .o_mclk(o_mclk),
        .o_mclk_oe(o_mclk_oe), .o_supply_sync_out(o_supply_sync_out),
        .o_supply_sync_oe(o_supply_sync_oe), .o_irq(o_irq));
    ampwm_stage_model u_stage (.i_clk(i_clk), .i_fault_req(flt_req),
        .o_protect(prot));

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits for pready, never assumes its timing
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do
            @(posedge i_clk);
        while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        // one idle edge so a following call never rewrites psel at once
        @(posedge i_clk);
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return o_pwm_pin[0];
            1: return o_supply_sync_out;
            3: return o_pwm_pin[1];
            default: return o_mclk;
        endcase
    endfunction

    // clocks between two rising edges of a watched output
    task automatic per_of(input int s, output int n);
        logic q;
        int k, e0, e1;
        q = sig(s);
        e0 = -1;
        e1 = -1;
        for (k = 0; k < 4000 && e1 < 0; k++)
        begin
            @(posedge i_clk);
            if (sig(s) === 1'b1 && q === 1'b0)
                if (e0 < 0) e0 = k;
                else e1 = k;
            q = sig(s);
        end
        n = e1 - e0;
    endtask

    task automatic hi_cnt(input int s, input int w, output int n);
        n = 0;
        // let a new setting reach the pin before counting
        repeat (3) @(posedge i_clk);
        repeat (w)
        begin
            @(posedge i_clk);
            if (sig(s) === 1'b1) n++;
            else if (sig(s) !== 1'b0) n = n + 1000;
        end
    endtask

    task automatic t_reset();
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h01C201F4);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0000FFFF);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({30'h0, o_idle_out, o_idle_oe}, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_pwm();
        i_duty[0] <= 10'h004;
        apb(1'b1, 12'h004, 32'h000C000A);
        apb(1'b1, 12'h080, 32'h0);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        per_of(0, p);
        chk(p, 10);
        hi_cnt(0, 10, h);
        chk(h, 4);
        apb(1'b1, 12'h084, 32'h10);
        hi_cnt(3, 10, h);
        chk(h, 6);
        apb(1'b1, 12'h040, 32'h1);
        hi_cnt(0, 10, h);
        chk(h, 3);
        hi_cnt(3, 10, h);
        chk(h, 5);
        apb(1'b1, 12'h040, 32'h0);
        apb(1'b1, 12'h080, 32'h20);
        hi_cnt(0, 20, h);
        chk(h, 12);
        apb(1'b1, 12'h040, 32'h0500);
        hi_cnt(0, 20, h);
        chk(h, 20);
        apb(1'b1, 12'h040, 32'h0);
        apb(1'b1, 12'h008, 32'h0);
        hi_cnt(0, 20, h);
        chk(h, 20);
        apb(1'b1, 12'h080, 32'h0);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h000, 32'h3);
        per_of(0, p);
        per_of(0, p);
        chk(p, 12);
        $display("pwm test done");
    endtask

    task automatic t_clocks();
        apb(1'b1, 12'h000, 32'h4);
        per_of(2, p);
        chk(p, 2);
        chk({o_mclk_oe, o_supply_sync_oe}, 2'h2);
        apb(1'b1, 12'h000, 32'hC);
        per_of(2, p);
        chk(p, 4);
        apb(1'b1, 12'h000, 32'h0);
        hi_cnt(2, 8, h);
        chk(h, 0);
        for (int r = 0; r < 6; r++)
        begin
            // am mode gives a carrier of 12, a multiple of four
            apb(1'b1, 12'h000, 32'h13 | (r << 8));
            repeat (24) @(posedge i_clk);
            per_of(1, p);
            per_of(1, p);
            chk(p, 6 * mul[r]);
            chk(o_supply_sync_oe, 1'b1);
        end
        apb(1'b1, 12'h000, 32'h1);
        hi_cnt(1, 8, h);
        chk(h, 0);
        chk({o_mclk_oe, o_supply_sync_oe}, 2'h0);
        $display("clock test done");
    endtask

    task automatic t_fault();
        apb(1'b1, 12'h000, 32'h80);
        repeat (3) @(posedge i_clk);
        chk({o_power_down, o_power_down_oe}, 2'h3);
        apb(1'b1, 12'h000, 32'hA1);
        apb(1'b1, 12'h018, 32'h1);
        flt_req <= 8'h01;
        repeat (10) @(posedge i_clk);
        chk({o_fault_out, o_fault_oe, o_power_down, o_irq}, 4'hF);
        hi_cnt(0, 20, h);
        chk(h, 0);
        flt_req <= 8'h00;
        repeat (10) @(posedge i_clk);
        apb(1'b1, 12'h018, 32'h0);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 1'b0);
        apb(1'b1, 12'h018, 32'h1);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 1'b1);
        apb(1'b1, 12'h01C, 32'h1);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 1'b0);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd[0], 1'b0);
        $display("fault test done");
    endtask

    task automatic t_idle();
        apb(1'b1, 12'h010, 32'h2);
        apb(1'b1, 12'h000, 32'h41);
        repeat (60) @(posedge i_clk);
        chk({o_idle_out, o_idle_oe}, 2'h3);
        hi_cnt(0, 24, h);
        chk(h, 0);
        i_audio_level <= 16'h0100;
        repeat (5) @(posedge i_clk);
        chk(o_idle_out, 1'b0);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd[2:0], 3'h6);
        $display("idle test done");
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    initial
    begin
        #(20 * 60000);
        fail_count++;
        summarize();
    end

    initial
    begin
        i_srst = 1'b1;
        {i_psel, i_penable, i_pwrite} = 3'h0;
        i_paddr = 12'h0;
        i_pwdata = 32'h0;
        i_duty = '0;
        i_audio_level = 16'h0;
        flt_req = 8'h00;
        repeat (16) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        t_reset();
        t_pwm();
        t_clocks();
        t_fault();
        t_idle();
        summarize();
    end
endmodule
